/* File: src/hlg_guard.sv */
// Heater limit guard: over-temperature shutdown, extremes and heater setup
//
// How it works
// - any input reading above its enabled limit forces every heater output off.
// - each limit spans 0 to 2999 K, resets to 0, and 0 disables its comparison.
// - each input has a unit choice of kelvin, celsius or sensor units for extremes.
// - highest and lowest reading per input are kept in that input's chosen units.
// - extreme tracking always runs and has no enable.
// - extremes clear at reset, on any input setting write, and on a clear command.
// - only output two has a type choice, current or voltage, resetting to current.
// - power budget is 50 W plus 25 W with output two current, 75 W plus 1 W with voltage.
// - output one may exceed 1.414 A only with output two on voltage and a 25 ohm setting.
// - output two cannot return to current while output one is above 1.414 A.
// - maximum current accepts any value from 0.1 A to 1.732 A on output one and to 1.414 A on output two, discrete ones included.
// - reset gives 25 ohm, 1.414 A on output one and 1 A on output two.
// - resistance and maximum current together cap delivered power.
// - each output has off, feedback, zone and open-loop modes; off sources nothing.
`timescale 1ns/1ns
module hlg_guard
  import hlg_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Sensor readings
  input  hlg_rdg_t               rdg0,
  input  hlg_rdg_t               rdg1,
  // Heater output stages
  output hlg_drive_t             drive1,
  output hlg_drive_t             drive2,
  output logic                   overtemp_shutdown,
  // Interrupt
  output logic                   irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  hlg_unit_t   unit_sel [2];
  logic [11:0] limit_k  [2];
  logic [1:0]  over;
  logic        type2_volt;
  logic        res1_high;
  logic        res2_high;
  logic [15:0] imax1;
  logic [15:0] imax2;
  hlg_mode_t   mode1;
  hlg_mode_t   mode2;
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] mask;
  logic signed [31:0] ext_max [2];
  logic signed [31:0] ext_min [2];
  hlg_rdg_t    rdg [2];

  logic              aw_hold;
  logic              w_hold;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;

  assign rdg[0] = rdg0;
  assign rdg[1] = rdg1;

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_hold;
  assign s_axi_wready  = !w_hold;

  wire       wr_fire = aw_hold && w_hold && !s_axi_bvalid;
  wire [7:0] wr_off  = 8'(aw_addr);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction

  wire [31:0] m_in0  = merge({30'h0, unit_sel[0]}, w_data, w_strb);
  wire [31:0] m_in1  = merge({30'h0, unit_sel[1]}, w_data, w_strb);
  wire [31:0] m_lim0 = merge({20'h0, limit_k[0]}, w_data, w_strb);
  wire [31:0] m_lim1 = merge({20'h0, limit_k[1]}, w_data, w_strb);
  wire [31:0] m_htr  = merge({29'h0, res2_high, res1_high, type2_volt}, w_data, w_strb);
  wire [31:0] m_i1   = merge({16'h0, imax1}, w_data, w_strb);
  wire [31:0] m_i2   = merge({16'h0, imax2}, w_data, w_strb);
  wire [31:0] m_mode = merge({28'h0, mode2, mode1}, w_data, w_strb);
  wire [31:0] m_mask = merge({29'h0, mask}, w_data, w_strb);

  wire sel_ctrl = wr_off == REG_CTRL;
  wire sel_in0  = wr_off == REG_IN0_CFG;
  wire sel_in1  = wr_off == REG_IN1_CFG;
  wire sel_lim0 = wr_off == REG_LIMIT0;
  wire sel_lim1 = wr_off == REG_LIMIT1;
  wire sel_htr  = wr_off == REG_HTR_CFG;
  wire sel_i1   = wr_off == REG_OUT1_MAX;
  wire sel_i2   = wr_off == REG_OUT2_MAX;
  wire sel_mode = wr_off == REG_MODE;
  wire sel_mask = wr_off == REG_MASK;
  wire wr_known = sel_ctrl | sel_in0 | sel_in1 | sel_lim0 | sel_lim1 | sel_htr
                | sel_i1 | sel_i2 | sel_mode | sel_mask;

  // the fourth unit code is not a choice
  wire bad_in0  = sel_in0 && (m_in0[31:2] != 30'h0 || m_in0[1:0] == UNIT_BAD);
  wire bad_in1  = sel_in1 && (m_in1[31:2] != 30'h0 || m_in1[1:0] == UNIT_BAD);
  wire bad_lim0 = sel_lim0 && (m_lim0[31:12] != 20'h0 || m_lim0[11:0] > LIMIT_MAX_K);
  wire bad_lim1 = sel_lim1 && (m_lim1[31:12] != 20'h0 || m_lim1[11:0] > LIMIT_MAX_K);
  // back to current blocked while output one runs high current
  wire htr_hi   = imax1 > IMAX_STD_MA;
  wire bad_htr  = sel_htr && htr_hi && (!m_htr[HTR_TYPE2_BIT] || m_htr[HTR_RES1_BIT]);
  // high current only in the voltage, 25 ohm configuration
  wire i1_hi    = m_i1[15:0] > IMAX_STD_MA;
  wire bad_i1   = sel_i1 && (m_i1[31:16] != 16'h0 || m_i1[15:0] < IMAX_MIN_MA
                || m_i1[15:0] > IMAX_TOP_MA || (i1_hi && (!type2_volt || res1_high)));
  wire bad_i2   = sel_i2 && (m_i2[31:16] != 16'h0 || m_i2[15:0] < IMAX_MIN_MA
                || m_i2[15:0] > IMAX_STD_MA);
  wire wr_bad   = !wr_known || bad_in0 || bad_in1 || bad_lim0 || bad_lim1 || bad_htr || bad_i1 || bad_i2;
  wire wr_ok    = wr_fire && !wr_bad;

  // any input setting write or clear command clears extremes
  wire ext_clear = wr_ok && ((sel_ctrl && w_data[CTRL_CLR_BIT] && w_strb[0])
                 || sel_in0 || sel_in1 || sel_lim0 || sel_lim1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      aw_addr <= '0;
    end else if (wr_fire) begin
      aw_hold <= 1'b0;
    end else if (s_axi_awvalid && !aw_hold) begin
      aw_hold <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (wr_fire) begin
      w_hold <= 1'b0;
    end else if (s_axi_wvalid && !w_hold) begin
      w_hold <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_bad ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unit_sel[0] <= UNIT_KELVIN;
      unit_sel[1] <= UNIT_KELVIN;
      limit_k[0]  <= LIMIT_RST;
      limit_k[1]  <= LIMIT_RST;
      // output two starts as current source
      type2_volt  <= 1'b0;
      res1_high   <= 1'b0;
      res2_high   <= 1'b0;
      imax1       <= OUT1_IMAX_RST;
      imax2       <= OUT2_IMAX_RST;
      mode1       <= MODE_OFF;
      mode2       <= MODE_OFF;
      mask        <= '0;
    end else if (wr_ok) begin
      if (sel_in0) unit_sel[0] <= hlg_unit_t'(m_in0[1:0]);
      if (sel_in1) unit_sel[1] <= hlg_unit_t'(m_in1[1:0]);
      if (sel_lim0) limit_k[0] <= m_lim0[11:0];
      if (sel_lim1) limit_k[1] <= m_lim1[11:0];
      if (sel_htr) begin
        type2_volt <= m_htr[HTR_TYPE2_BIT];
        res1_high  <= m_htr[HTR_RES1_BIT];
        res2_high  <= m_htr[HTR_RES2_BIT];
      end
      if (sel_i1) imax1 <= m_i1[15:0];
      if (sel_i2) imax2 <= m_i2[15:0];
      if (sel_mode) begin
        mode1 <= hlg_mode_t'(m_mode[1:0]);
        mode2 <= hlg_mode_t'(m_mode[3:2]);
      end
      if (sel_mask) mask <= m_mask[ST_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Per-input limit and extremes
  // ----------------------------------------------------------------
  logic [1:0] over_rise;

  for (genvar i = 0; i < 2; i++) begin : g_in
    wire [31:0]        lim_mk = 32'(limit_k[i]) * MK_PER_K;
    wire               above  = limit_k[i] != LIMIT_RST && $unsigned(rdg[i].kelvin_mk) > lim_mk;
    wire signed [31:0] pick   = unit_sel[i] == UNIT_CELSIUS ? rdg[i].celsius_mc :
                                unit_sel[i] == UNIT_SENSOR  ? rdg[i].sensor : rdg[i].kelvin_mk;

    assign over_rise[i] = rdg[i].valid && above && !over[i];

    // flag holds until a reading at or below the limit, or until the limit is set to 0
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        over[i] <= 1'b0;
      end else if (limit_k[i] == LIMIT_RST) begin
        over[i] <= 1'b0;
      end else if (rdg[i].valid) begin
        over[i] <= above;
      end
    end

    hlg_extreme u_ext (
      .aclk         (aclk),
      .aresetn      (aresetn),
      .clear        (ext_clear),
      .sample_valid (rdg[i].valid),
      .sample       (pick),
      .max_val      (ext_max[i]),
      .min_val      (ext_min[i])
    );
  end

  // ----------------------------------------------------------------
  // Heater drive
  // ----------------------------------------------------------------
  // any over-limit input shuts down every output
  assign overtemp_shutdown = |over;

  // cap is I squared times R, clipped to the budget
  wire [31:0] ohm1   = 32'(res1_high ? RES_HIGH_OHM : RES_LOW_OHM);
  wire [31:0] ohm2   = 32'(res2_high ? RES_HIGH_OHM : RES_LOW_OHM);
  wire [31:0] raw1   = 32'(32'(imax1) * 32'(imax1) * ohm1 / UW_PER_MW);
  wire [31:0] raw2   = 32'(32'(imax2) * 32'(imax2) * ohm2 / UW_PER_MW);
  wire [31:0] bud1   = type2_volt ? BUD1_VOLT_MW : BUD1_CUR_MW;
  wire [31:0] bud2   = type2_volt ? BUD2_VOLT_MW : BUD2_CUR_MW;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive1 <= '0;
      drive2 <= '0;
    end else begin
      // off mode or shutdown sources no current
      drive1.enable    <= mode1 != MODE_OFF && !overtemp_shutdown;
      drive1.volt_type <= 1'b0;
      drive1.imax_ma   <= imax1;
      drive1.cap_mw    <= raw1 < bud1 ? raw1 : bud1;
      drive2.enable    <= mode2 != MODE_OFF && !overtemp_shutdown;
      // selects the active stage and connector
      drive2.volt_type <= type2_volt;
      drive2.imax_ma   <= imax2;
      drive2.cap_mw    <= raw2 < bud2 ? raw2 : bud2;
    end
  end

  // ----------------------------------------------------------------
  // Read channel, status and interrupt
  // ----------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  wire       rd_fire = s_axi_arvalid && !s_axi_rvalid;
  wire [7:0] rd_off  = 8'(s_axi_araddr);
  wire       rd_stat = rd_fire && rd_off == REG_STATUS;

  logic [31:0] rd_mux;
  logic        rd_hit;

  always_comb begin
    rd_hit = 1'b1;
    unique case (rd_off)
      REG_CTRL:     rd_mux = '0;
      REG_IN0_CFG:  rd_mux = {30'h0, unit_sel[0]};
      REG_IN1_CFG:  rd_mux = {30'h0, unit_sel[1]};
      REG_LIMIT0:   rd_mux = {20'h0, limit_k[0]};
      REG_LIMIT1:   rd_mux = {20'h0, limit_k[1]};
      REG_HTR_CFG:  rd_mux = {29'h0, res2_high, res1_high, type2_volt};
      REG_OUT1_MAX: rd_mux = {16'h0, imax1};
      REG_OUT2_MAX: rd_mux = {16'h0, imax2};
      REG_MODE:     rd_mux = {28'h0, mode2, mode1};
      REG_STATUS:   rd_mux = {29'h0, status};
      REG_MASK:     rd_mux = {29'h0, mask};
      REG_MAX0:     rd_mux = ext_max[0];
      REG_MIN0:     rd_mux = ext_min[0];
      REG_MAX1:     rd_mux = ext_max[1];
      REG_MIN1:     rd_mux = ext_min[1];
      REG_PWR1:     rd_mux = drive1.cap_mw;
      REG_PWR2:     rd_mux = drive2.cap_mw;
      default: begin
        rd_mux = '0;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Events set, a status read clears; set wins in the same cycle
  wire [ST_W-1:0] ev = {wr_fire && wr_bad, over_rise[1], over_rise[0]};
  wire [ST_W-1:0] next_status = (rd_stat ? {ST_W{1'b0}} : status) | ev;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= '0;
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      irq    <= |(next_status & mask);
    end
  end

endmodule // hlg_guard

/* File: src/hlg_pkg.sv */
// Shared constants and types for the heater limit guard
package hlg_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_IN0_CFG  = 8'h04;
  localparam logic [7:0] REG_IN1_CFG  = 8'h08;
  localparam logic [7:0] REG_LIMIT0   = 8'h0C;
  localparam logic [7:0] REG_LIMIT1   = 8'h10;
  localparam logic [7:0] REG_HTR_CFG  = 8'h14;
  localparam logic [7:0] REG_OUT1_MAX = 8'h18;
  localparam logic [7:0] REG_OUT2_MAX = 8'h1C;
  localparam logic [7:0] REG_MODE     = 8'h20;
  localparam logic [7:0] REG_STATUS   = 8'h24;
  localparam logic [7:0] REG_MASK     = 8'h28;
  localparam logic [7:0] REG_MAX0     = 8'h2C;
  localparam logic [7:0] REG_MIN0     = 8'h30;
  localparam logic [7:0] REG_MAX1     = 8'h34;
  localparam logic [7:0] REG_MIN1     = 8'h38;
  localparam logic [7:0] REG_PWR1     = 8'h3C;
  localparam logic [7:0] REG_PWR2     = 8'h40;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_CLR_BIT   = 0;
  localparam int HTR_TYPE2_BIT  = 0;
  localparam int HTR_RES1_BIT   = 1;
  localparam int HTR_RES2_BIT   = 2;
  localparam int ST_OT0_BIT     = 0;
  localparam int ST_OT1_BIT     = 1;
  localparam int ST_REJ_BIT     = 2;
  localparam int ST_W           = 3;

  // ----------------------------------------------------------------
  // Values, limits and reset values
  // ----------------------------------------------------------------
  localparam logic [11:0] LIMIT_MAX_K    = 12'hBB7;    // 2999 K
  localparam logic [11:0] LIMIT_RST      = 12'h000;
  localparam logic [31:0] MK_PER_K       = 32'h0000_03E8;
  localparam logic [15:0] IMAX_MIN_MA    = 16'h0064;   // 0.1 A
  localparam logic [15:0] IMAX_TOP_MA    = 16'h06C4;   // 1.732 A
  localparam logic [15:0] IMAX_STD_MA    = 16'h0586;   // 1.414 A
  localparam logic [15:0] OUT1_IMAX_RST  = 16'h0586;
  localparam logic [15:0] OUT2_IMAX_RST  = 16'h03E8;   // 1 A
  localparam logic [7:0]  RES_LOW_OHM    = 8'h19;      // 25 ohm
  localparam logic [7:0]  RES_HIGH_OHM   = 8'h32;      // 50 ohm
  localparam logic [31:0] UW_PER_MW      = 32'h0000_03E8;
  localparam logic [31:0] BUD1_CUR_MW    = 32'h0000_C350; // 50 W
  localparam logic [31:0] BUD1_VOLT_MW   = 32'h0001_24F8; // 75 W
  localparam logic [31:0] BUD2_CUR_MW    = 32'h0000_61A8; // 25 W
  localparam logic [31:0] BUD2_VOLT_MW   = 32'h0000_03E8; // 1 W
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {UNIT_KELVIN, UNIT_CELSIUS, UNIT_SENSOR, UNIT_BAD} hlg_unit_t;
  typedef enum logic [1:0] {MODE_OFF, MODE_PID, MODE_ZONE, MODE_OPEN} hlg_mode_t;

  typedef struct packed {
    logic               valid;
    logic signed [31:0] kelvin_mk;
    logic signed [31:0] celsius_mc;
    logic signed [31:0] sensor;
  } hlg_rdg_t;

  typedef struct packed {
    logic        enable;
    logic        volt_type;
    logic [15:0] imax_ma;
    logic [31:0] cap_mw;
  } hlg_drive_t;

endpackage

/* File: src/hlg_extreme.sv */
// Highest and lowest value tracker for one input
`timescale 1ns/1ns
module hlg_extreme
  import hlg_pkg::*;
(
  // Clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // Control and sample
  input  wire logic               clear,
  input  wire logic               sample_valid,
  input  wire logic signed [31:0] sample,
  // Stored extremes
  output logic signed [31:0]      max_val,
  output logic signed [31:0]      min_val
);

  logic seen;

  // Clear has priority; a sample in the same cycle is dropped with the old set
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      seen    <= 1'b0;
      max_val <= '0;
      min_val <= '0;
    end else if (sample_valid) begin
      seen <= 1'b1;
      if (!seen || sample > max_val) begin
        max_val <= sample;
      end
      if (!seen || sample < min_val) begin
        min_val <= sample;
      end
    end
  end

endmodule // hlg_extreme

/* File: verification/hlg_sensor_model.sv */
// Sensor path model: one reading pulse per request from the bench
`timescale 1ns/1ns
module hlg_sensor_model
  import hlg_pkg::*;
(
  // Clock
  input  wire logic        aclk,
  // Request from the bench
  input  wire logic        req,
  input  wire logic        ch,
  input  wire logic [31:0] mk,
  // Readings
  output hlg_rdg_t         rdg0,
  output hlg_rdg_t         rdg1
);
  logic [31:0] junk = 32'h0;
  hlg_rdg_t    now;
  // Raw units are a quarter of the milli-kelvin value
  assign now = {1'h1, mk, mk - 32'h0004_2AFE, mk >> 2};
  always_ff @(posedge aclk) begin
    junk <= junk + 32'h9E37_79B9;
    rdg0 <= (req && !ch) ? now : {1'h0, junk, ~junk, junk};
    rdg1 <= (req && ch) ? now : {1'h0, ~junk, junk, ~junk};
  end
endmodule // hlg_sensor_model

/* File: verification/hlg_guard_properties.sv */
// Port-level checks for the heater limit guard
`timescale 1ns/1ns
module hlg_guard_properties
  import hlg_pkg::*;
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus handshakes
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Readings and drives
  input hlg_rdg_t         rdg0,
  input hlg_rdg_t         rdg1,
  input hlg_drive_t       drive1,
  input hlg_drive_t       drive2,
  input wire logic        overtemp_shutdown
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_off;
    !drive1.enable && !drive2.enable;
  endsequence
  sequence s_high1;
    drive1.imax_ma > IMAX_STD_MA;
  endsequence
  a_trip_all_off: assert property (overtemp_shutdown |=> s_off)
    else $error("outputs on during shutdown");
  a_trip_on_rdg: assert property ($rose(overtemp_shutdown) |-> $past(rdg0.valid || rdg1.valid))
    else $error("shutdown rose without a reading");
  a_out1_no_type: assert property (!drive1.volt_type)
    else $error("output one shows voltage type");
  a_budget_cap: assert property ((drive1.cap_mw <= (drive2.volt_type ? BUD1_VOLT_MW : BUD1_CUR_MW))
    && (drive2.cap_mw <= (drive2.volt_type ? BUD2_VOLT_MW : BUD2_CUR_MW))) else $error("power cap over budget");
  a_high_needs_volt: assert property (s_high1 |-> drive2.volt_type)
    else $error("high current without voltage type");
  a_type_locked: assert property (s_high1 and drive2.volt_type |=> drive2.volt_type)
    else $error("output two left voltage type");
  a_imax_range: assert property ($past(aresetn) |-> drive1.imax_ma inside {[IMAX_MIN_MA:IMAX_TOP_MA]})
    else $error("max current out of range");
  a_reset_setup: assert property ($rose(aresetn) |=> drive1.imax_ma == OUT1_IMAX_RST
    && drive2.imax_ma == OUT2_IMAX_RST && !drive2.volt_type) else $error("wrong heater setup after reset");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed while waiting");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response changed while waiting");
endmodule // hlg_guard_properties

bind hlg_guard hlg_guard_properties u_props (.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .rdg0(rdg0), .rdg1(rdg1), .drive1(drive1), .drive2(drive2),
  .overtemp_shutdown(overtemp_shutdown));

/* File: verification/test_heater_limit_guard.sv */
// Self-checking bench for the heater limit guard
`timescale 1ns/1ns
module test_heater_limit_guard
  import hlg_pkg::*;
;
  logic        aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
  logic        req = 1'h0, ch = 1'h0;
  logic [7:0]  aw = 8'h00, ar = 8'h00;
  logic [31:0] wd = 32'h0, mk = 32'h0, rd, data;
  logic        awr, wrr, arr, bv, rv, shut, irq;
  logic [1:0]  br, rr, resp;
  hlg_rdg_t    rdg0, rdg1;
  hlg_drive_t  d1, d2;
  int          error_cnt = 0, compares = 0;
  always #4 aclk = ~aclk;
  hlg_guard uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .rdg0(rdg0), .rdg1(rdg1),
    .drive1(d1), .drive2(d2), .overtemp_shutdown(shut), .irq(irq));
  hlg_sensor_model u_model (.aclk(aclk), .req(req), .ch(ch), .mk(mk), .rdg0(rdg0), .rdg1(rdg1));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("Counts: %0d compares, %0d errors", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  // One bus cycle; ready and answers are looked at in the low half of the clock
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic got, ta, tw, tr;
    n = 0;
    got = 1'h0;
    @(posedge aclk);
    aw <= a;
    ar <= a;
    wd <= d;
    awv <= w;
    wv <= w;
    arv <= !w;
    bry <= w;
    rry <= !w;
    while (!got) begin
      @(negedge aclk);
      ta = awv && awr;
      tw = wv && wrr;
      tr = arv && arr;
      got = w ? bv : rv;
      resp = w ? br : rr;
      data = rd;
      n++;
      if (n > 50) begin
        error_cnt++;
        $display("Error bus: expected answer, seen timeout");
        end_of_test();
      end
      @(posedge aclk);
      if (ta) awv <= 1'h0;
      if (tw) wv <= 1'h0;
      if (tr) arv <= 1'h0;
      if (got) bry <= 1'h0;
      if (got) rry <= 1'h0;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bus(1'h1, a, d);
    chk("bresp", 32'(er), 32'(resp));
  endtask
  task automatic rdx(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk("rdata", e, data);
  endtask
  task automatic settle();
    repeat (2) @(posedge aclk);
    #1;
  endtask
  task automatic feed(input logic c, input logic [31:0] v);
    @(posedge aclk);
    req <= 1'h1;
    ch <= c;
    mk <= v;
    @(posedge aclk);
    req <= 1'h0;
    repeat (3) @(posedge aclk);
    #1;
  endtask
  function automatic logic [31:0] capf(input logic [31:0] i, input logic [31:0] r, input logic [31:0] b);
    logic [31:0] p;
    p = i * i * r / 32'h3E8;
    return (p < b) ? p : b;
  endfunction
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdx(REG_OUT1_MAX, 32'h0000_0586);
    rdx(REG_OUT2_MAX, 32'h0000_03E8);
    rdx(REG_HTR_CFG, 32'h0);
    rdx(REG_LIMIT0, 32'h0);
    chk("enable1", 32'h0, 32'(d1.enable));
    rdx(8'hFC, 32'h0);
    chk("rresp", 32'(RESP_SLVERR), 32'(resp));
    $display("reset test done");
  endtask
  task automatic t_limit();
    logic [7:0] lim;
    wr(REG_MODE, 32'h5, RESP_OKAY);
    wr(REG_MASK, 32'h1, RESP_OKAY);
    for (int c = 0; c < 2; c++) begin
      lim = c ? REG_LIMIT1 : REG_LIMIT0;
      feed(c[0], 32'h05F5_E100);
      chk("shutdown", 32'h0, 32'(shut));
      wr(lim, 32'hBB8, RESP_SLVERR);
      wr(lim, 32'hBB7, RESP_OKAY);
      feed(c[0], 32'h002D_C2D9);
      chk("shutdown", 32'h1, 32'(shut));
      chk("enables", 32'h0, 32'({d1.enable, d2.enable}));
      chk("irq", 32'(c == 0), 32'(irq));
      feed(c[0], 32'h002D_C2D8);
      chk("enables", 32'h3, 32'({d1.enable, d2.enable}));
      // The out-of-range limit write above also set the rejected-write bit
      rdx(REG_STATUS, 32'((1 << c) | (1 << ST_REJ_BIT)));
      rdx(REG_STATUS, 32'h0);
      chk("irq", 32'h0, 32'(irq));
      wr(lim, 32'h0, RESP_OKAY);
    end
    $display("limit test done");
  endtask
  task automatic t_extreme();
    feed(1'h0, 32'h2710);
    feed(1'h0, 32'h1388);
    feed(1'h0, 32'h4E20);
    rdx(REG_MAX0, 32'h4E20);
    rdx(REG_MIN0, 32'h1388);
    wr(REG_IN0_CFG, 32'h1, RESP_OKAY);
    rdx(REG_MAX0, 32'h0);
    feed(1'h0, 32'h2710);
    rdx(REG_MAX0, 32'h2710 - 32'h0004_2AFE);
    wr(REG_IN0_CFG, 32'h2, RESP_OKAY);
    feed(1'h0, 32'h2710);
    rdx(REG_MIN0, 32'h09C4);
    wr(REG_IN0_CFG, 32'h3, RESP_SLVERR);
    wr(REG_CTRL, 32'h1, RESP_OKAY);
    rdx(REG_MIN0, 32'h0);
    $display("extreme test done");
  endtask
  task automatic t_heater();
    wr(REG_OUT1_MAX, 32'h06C4, RESP_SLVERR);
    wr(REG_HTR_CFG, 32'h3, RESP_OKAY);
    wr(REG_OUT1_MAX, 32'h06C4, RESP_SLVERR);
    wr(REG_HTR_CFG, 32'h1, RESP_OKAY);
    wr(REG_OUT1_MAX, 32'h06C4, RESP_OKAY);
    settle();
    chk("cap1", capf(32'h6C4, 32'h19, BUD1_VOLT_MW), d1.cap_mw);
    chk("cap2", capf(32'h3E8, 32'h19, BUD2_VOLT_MW), d2.cap_mw);
    chk("type2", 32'h1, 32'(d2.volt_type));
    chk("imax1", 32'h6C4, 32'(d1.imax_ma));
    wr(REG_HTR_CFG, 32'h0, RESP_SLVERR);
    rdx(REG_STATUS, 32'h4);
    wr(REG_OUT1_MAX, 32'h0586, RESP_OKAY);
    wr(REG_HTR_CFG, 32'h0, RESP_OKAY);
    settle();
    chk("cap1", capf(32'h586, 32'h19, BUD1_CUR_MW), d1.cap_mw);
    chk("cap2", capf(32'h3E8, 32'h19, BUD2_CUR_MW), d2.cap_mw);
    wr(REG_OUT1_MAX, 32'h63, RESP_SLVERR);
    wr(REG_OUT1_MAX, 32'h64, RESP_OKAY);
    // Both outputs on the 50 ohm setting
    wr(REG_HTR_CFG, 32'h6, RESP_OKAY);
    settle();
    chk("cap1", capf(32'h64, 32'h32, BUD1_CUR_MW), d1.cap_mw);
    for (int m = 0; m < 4; m++) begin
      wr(REG_MODE, 32'(m * 5), RESP_OKAY);
      settle();
      chk("enable2", 32'(m != 0), 32'(d2.enable));
    end
    $display("heater test done");
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    t_limit();
    t_extreme();
    t_heater();
    end_of_test();
  end
endmodule // test_heater_limit_guard
